// file: verilog/srs_pkg.sv
// sensor result/status register bank: shared constants and types
// assumes both ends and the bench refer to these by srs_pkg::name
package srs_pkg;

  // ----------------------------------------------------------------
  // link widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8; // byte address of a 16-bit word
  localparam int DATA_W = 16; // one register word

  // ----------------------------------------------------------------
  // device register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TEMP = 8'h2e; // corrected temperature
  localparam logic [7:0] OFS_PRESS = 8'h30; // corrected pressure
  localparam logic [7:0] OFS_SYNC = 8'h32; // synced status copy
  localparam logic [7:0] OFS_MAIN = 8'h36; // main status
  localparam logic [7:0] OFS_SER_LO = 8'h50; // serial number low word
  localparam logic [7:0] OFS_SER_HI = 8'h52; // serial number high word
  localparam logic [7:0] WORD_STEP = 8'h02; // address step per word

  // ----------------------------------------------------------------
  // status bit positions and masks
  // ----------------------------------------------------------------
  localparam int IDLE_BIT = 0;
  localparam int S_UP_BIT = 3;
  localparam int T_UP_BIT = 4;
  localparam int BSF_BIT = 7;
  localparam int BCF_BIT = 8;
  localparam int SAT_BIT = 10;
  localparam int CRC_BIT = 11;
  localparam int S_MISS_BIT = 14;
  localparam int T_MISS_BIT = 15;
  localparam logic [15:0] EVENT_MASK = 16'hc998; // latched event bits
  localparam logic [15:0] SYNC_COPY_MASK = 16'hffe1; // bits 15:5 and 0
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000; // results before first load

  // ----------------------------------------------------------------
  // host controller apb map
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] H_CTRL = 12'h000; // write starts an order
  localparam logic [11:0] H_WDATA = 12'h004; // word for a link write
  localparam logic [11:0] H_STAT = 12'h008; // controller state
  localparam logic [11:0] H_RD0 = 12'h00c; // first word read
  localparam logic [11:0] H_RD1 = 12'h010; // second word of a burst
  localparam logic [11:0] H_RD2 = 12'h014; // third word of a burst
  localparam int CTRL_WE_BIT = 8; // 1: link write
  localparam int CTRL_BURST_BIT = 9; // 1: three-word read from temp
  localparam int STAT_BUSY = 0;
  localparam int STAT_READY = 1; // both update flags seen once
  localparam int STAT_T_FRESH = 2;
  localparam int STAT_S_FRESH = 3;
  localparam logic [1:0] BURST_LAST = 2'h2; // index of third word

  typedef enum logic {SRS_H_IDLE, SRS_H_REQ} srs_host_state_type;

endpackage

// file: verilog/srs_link_if.sv
// register link between host controller and sensor register bank
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface srs_link_if;
  logic req; // host request, held until ack
  logic we; // 1 write, 0 read
  logic [7:0] addr; // word byte address
  logic [15:0] wdata; // write word
  logic ack; // device answer, one cycle
  logic [15:0] rdata; // read word, valid with ack

  modport dev_mp (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host_mp (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// file: verilog/srs_event_flag.sv
// one sticky event bit; a set in the clearing cycle wins
// assumes set and clear are synchronous single-cycle terms
`timescale 1ns/100ps
module srs_event_flag (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  // set ORed over the held value so a coinciding event is never lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= set | (flag_q & ~clr);
    end
  end

endmodule

// file: verilog/srs_device.sv
// sensor register bank: results, main and synced status, serial number
// assumes the link ends are on clk and measurement strobes are clk-synchronous
//
// Our own choice: the register link port.
`timescale 1ns/100ps
module srs_device #(
  parameter logic [31:0] SERIAL_NUMBER = 32'h5a5a_0001 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  srs_link_if.dev_mp link,
  input wire logic temp_load,
  input wire logic [15:0] temp_value,
  input wire logic press_load,
  input wire logic [15:0] press_value,
  input wire logic result_clamped,
  input wire logic chip_idle,
  input wire logic bridge_supply_fault,
  input wire logic bridge_check_fault,
  input wire logic link_crc_fault,
  input wire logic cfg_crc_fault,
  output logic results_blocked
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // offsets up to 0x52 must fit the link address
  if (srs_pkg::ADDR_W < 7) begin : g_addr_check
    $error("link address too narrow for the register map");
  end

  // ----------------------------------------------------------------
  // link accept and decode
  // ----------------------------------------------------------------
  logic ack_q; // answer strobe
  logic [15:0] rdata_q; // answered word
  logic accept; // request taken this edge
  logic rd_acc; // read taken
  logic wr_acc; // write taken
  logic hit_temp;
  logic hit_press;
  logic hit_sync;
  logic hit_main;
  logic hit_ser_lo;
  logic hit_ser_hi;

  // a held request is taken once; the ack cycle blocks a repeat
  assign accept = link.req & ~ack_q;
  assign rd_acc = accept & ~link.we;
  assign wr_acc = accept & link.we;
  assign hit_temp = (link.addr == srs_pkg::OFS_TEMP);
  assign hit_press = (link.addr == srs_pkg::OFS_PRESS);
  assign hit_sync = (link.addr == srs_pkg::OFS_SYNC);
  assign hit_main = (link.addr == srs_pkg::OFS_MAIN);
  assign hit_ser_lo = (link.addr == srs_pkg::OFS_SER_LO);
  assign hit_ser_hi = (link.addr == srs_pkg::OFS_SER_HI);

  // read side effects: clearing and sync copy happen at the accept edge
  logic rd_temp;
  logic rd_press;
  assign rd_temp = rd_acc & hit_temp;
  assign rd_press = rd_acc & hit_press;

  // ----------------------------------------------------------------
  // configuration integrity gate
  // ----------------------------------------------------------------
  logic cfg_bad_q; // sticky once the memory check failed
  logic upd_ok; // result loads permitted

  // stays set until reset; the device never recovers without a reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_bad_q <= 1'b0;
    end else begin
      cfg_bad_q <= cfg_bad_q | cfg_crc_fault;
    end
  end

  // the raw fault also blocks so the failing cycle itself loads nothing
  assign upd_ok = ~cfg_bad_q & ~cfg_crc_fault;
  assign results_blocked = cfg_bad_q;

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  logic t_upd; // temperature load accepted
  logic s_upd; // pressure load accepted
  logic [15:0] temp_q; // corrected temperature
  logic [15:0] press_q; // corrected pressure
  logic sat_q; // last loaded value was clamped

  assign t_upd = temp_load & upd_ok;
  assign s_upd = press_load & upd_ok;

  // reset value carries no meaning; host waits for the update flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_q <= srs_pkg::WORD_RESET;
    end else if (t_upd) begin
      temp_q <= temp_value;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      press_q <= srs_pkg::WORD_RESET;
    end else if (s_upd) begin
      press_q <= press_value;
    end
  end

  // clamp condition belongs to the current results, so it moves with them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sat_q <= 1'b0;
    end else if (t_upd | s_upd) begin
      sat_q <= result_clamped;
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  logic [15:0] ev_set; // per-bit set terms
  logic [15:0] ev_clr; // per-bit clear terms
  logic [15:0] ev_q; // latched events
  logic [15:0] sw_clr; // write-one-to-clear mask

  // only the main status word clears; the synced copy does not
  assign sw_clr = (wr_acc & hit_main) ? link.wdata : 16'h0000;

  always_comb begin
    ev_set = 16'h0000;
    ev_set[srs_pkg::S_UP_BIT] = s_upd;
    ev_set[srs_pkg::T_UP_BIT] = t_upd;
    ev_set[srs_pkg::BSF_BIT] = bridge_supply_fault;
    ev_set[srs_pkg::BCF_BIT] = bridge_check_fault;
    ev_set[srs_pkg::CRC_BIT] = link_crc_fault;
    // unread value overwritten; a read in the same cycle counts as read
    ev_set[srs_pkg::S_MISS_BIT] = s_upd & ev_q[srs_pkg::S_UP_BIT] & ~rd_press;
    ev_set[srs_pkg::T_MISS_BIT] = t_upd & ev_q[srs_pkg::T_UP_BIT] & ~rd_temp;
  end

  always_comb begin
    ev_clr = sw_clr & srs_pkg::EVENT_MASK;
    ev_clr[srs_pkg::S_UP_BIT] = sw_clr[srs_pkg::S_UP_BIT] | rd_press;
    ev_clr[srs_pkg::T_UP_BIT] = sw_clr[srs_pkg::T_UP_BIT] | rd_temp;
  end

  // one latch per event bit; reserved positions get no flop at all
  for (genvar i = 0; i < 16; i++) begin : g_ev
    if (srs_pkg::EVENT_MASK[i]) begin : g_on
      srs_event_flag u_flag (
        .clk(clk),
        .rst_b(rst_b),
        .set(ev_set[i]),
        .clr(ev_clr[i]),
        .flag_q(ev_q[i])
      );
    end else begin : g_off
      assign ev_q[i] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------
  logic [15:0] main_word; // main status as read
  logic sync_s_q; // pressure flag at last pressure read
  logic sync_t_q; // temperature flag at last temperature read
  logic [15:0] sync_word; // synced status as read

  // idle is live straight from the sequencer; clamp is held from the last load
  always_comb begin
    main_word = ev_q & srs_pkg::EVENT_MASK;
    main_word[srs_pkg::SAT_BIT] = sat_q;
    main_word[srs_pkg::IDLE_BIT] = chip_idle;
  end

  // flag value before this read's own clear is what gets copied
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_s_q <= 1'b0;
      sync_t_q <= 1'b0;
    end else begin
      if (rd_press) begin
        sync_s_q <= ev_q[srs_pkg::S_UP_BIT];
      end
      if (rd_temp) begin
        sync_t_q <= ev_q[srs_pkg::T_UP_BIT];
      end
    end
  end

  assign sync_word = (main_word & srs_pkg::SYNC_COPY_MASK)
    | (16'(sync_s_q) << srs_pkg::S_UP_BIT)
    | (16'(sync_t_q) << srs_pkg::T_UP_BIT);

  // ----------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------
  logic [15:0] rd_mux; // word selected by address

  // unmapped addresses read as zero
  assign rd_mux = hit_temp ? temp_q :
                  hit_press ? press_q :
                  hit_sync ? sync_word :
                  hit_main ? main_word :
                  hit_ser_lo ? SERIAL_NUMBER[15:0] :
                  hit_ser_hi ? SERIAL_NUMBER[31:16] :
                  16'h0000;

  // writes anywhere but main status only earn an ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= srs_pkg::WORD_RESET;
    end else begin
      ack_q <= accept;
      if (rd_acc) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;

endmodule

// file: verilog/srs_host.sv
// host controller: apb slave that runs reads, writes and bursts on the link
// assumes apb on clk; device answers each request with a one-cycle ack
`timescale 1ns/100ps
module srs_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  srs_link_if.host_mp link
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup; // setup phase
  logic acc_wr; // access-phase write
  logic hit_any; // mapped offset
  logic start; // ctrl written while idle
  srs_pkg::srs_host_state_type st_q;

  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign hit_any = (paddr == srs_pkg::H_CTRL) | (paddr == srs_pkg::H_WDATA)
    | (paddr == srs_pkg::H_STAT) | (paddr == srs_pkg::H_RD0)
    | (paddr == srs_pkg::H_RD1) | (paddr == srs_pkg::H_RD2);
  // orders given while busy are dropped
  assign start = acc_wr & (paddr == srs_pkg::H_CTRL) & (st_q == srs_pkg::SRS_H_IDLE);
  assign pready = 1'b1; // every access ends in one access cycle
  assign pslverr = psel & penable & ~hit_any;

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  logic we_q;
  logic burst_q;
  logic [7:0] addr_q;
  logic [15:0] wdata_q;
  logic [1:0] idx_q; // burst word index
  logic [15:0] rd_q [3]; // words read
  logic seen_t_q; // temperature update observed once
  logic seen_s_q; // pressure update observed once
  logic status_rd; // answer carries a status word
  logic more; // burst has words left

  assign more = burst_q & (idx_q != srs_pkg::BURST_LAST);
  assign status_rd = link.ack & ~we_q
    & ((addr_q == srs_pkg::OFS_MAIN) | (addr_q == srs_pkg::OFS_SYNC));

  // burst always begins at temperature so the order is T, P, synced status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= srs_pkg::SRS_H_IDLE;
      we_q <= 1'b0;
      burst_q <= 1'b0;
      addr_q <= 8'h00;
      idx_q <= 2'h0;
    end else begin
      case (st_q)
        srs_pkg::SRS_H_IDLE: begin
          if (start) begin
            st_q <= srs_pkg::SRS_H_REQ;
            we_q <= pwdata[srs_pkg::CTRL_WE_BIT];
            burst_q <= pwdata[srs_pkg::CTRL_BURST_BIT] & ~pwdata[srs_pkg::CTRL_WE_BIT];
            addr_q <= pwdata[srs_pkg::CTRL_BURST_BIT] ? srs_pkg::OFS_TEMP : pwdata[7:0];
            idx_q <= 2'h0;
          end
        end
        srs_pkg::SRS_H_REQ: begin
          if (link.ack && more) begin
            addr_q <= addr_q + srs_pkg::WORD_STEP;
            idx_q <= idx_q + 2'h1;
          end else if (link.ack) begin
            st_q <= srs_pkg::SRS_H_IDLE;
          end
        end
        default: begin
          st_q <= srs_pkg::SRS_H_IDLE;
        end
      endcase
    end
  end

  // write word latched from apb; read words captured on ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdata_q <= 16'h0000;
      rd_q[0] <= 16'h0000;
      rd_q[1] <= 16'h0000;
      rd_q[2] <= 16'h0000;
    end else begin
      if (acc_wr && (paddr == srs_pkg::H_WDATA)) begin
        wdata_q <= pwdata[15:0];
      end
      if (link.ack && !we_q) begin
        rd_q[idx_q] <= link.rdata;
      end
    end
  end

  // results only trusted after both flags were seen; no fixed delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_t_q <= 1'b0;
      seen_s_q <= 1'b0;
    end else if (status_rd) begin
      seen_t_q <= seen_t_q | link.rdata[srs_pkg::T_UP_BIT];
      seen_s_q <= seen_s_q | link.rdata[srs_pkg::S_UP_BIT];
    end
  end

  assign link.req = (st_q == srs_pkg::SRS_H_REQ);
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;

  // ----------------------------------------------------------------
  // apb read data, registered in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  assign stat_word = {28'h0000000, rd_q[2][srs_pkg::S_UP_BIT], rd_q[2][srs_pkg::T_UP_BIT],
    seen_t_q & seen_s_q, st_q == srs_pkg::SRS_H_REQ};
  assign rd_mux = (paddr == srs_pkg::H_CTRL) ? {22'h000000, burst_q, we_q, addr_q} :
                  (paddr == srs_pkg::H_WDATA) ? {16'h0000, wdata_q} :
                  (paddr == srs_pkg::H_STAT) ? stat_word :
                  (paddr == srs_pkg::H_RD0) ? {16'h0000, rd_q[0]} :
                  (paddr == srs_pkg::H_RD1) ? {16'h0000, rd_q[1]} :
                  (paddr == srs_pkg::H_RD2) ? {16'h0000, rd_q[2]} :
                  32'h00000000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

endmodule

// file: verification/srs_link_sva.sv
// checker for the register link between host controller and device
// assumes it watches the link interface signals on one clock
`timescale 1ns/100ps
module srs_link_sva #(
  parameter logic [31:0] SERIAL_NUMBER = 32'h5a5a_0001 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  // reserved places of both status words
  localparam logic [15:0] RSV_MASK = 16'h3266;
  // host holds addr and we until ack, so they name the answered read
  wire rd_ack = ack && !we;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------
  AST_ACK_NEXT: assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  AST_ACK_ONE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(req))
    else $error("ack without request");
  AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
    && $stable(wdata)) else $error("request changed before ack");
  AST_RDATA_HOLD: assert property (!(req && !ack && !we) |=> $stable(rdata))
    else $error("read word changed without a read");

  // ----------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------
  AST_SER_LO: assert property (
    rd_ack && addr == srs_pkg::OFS_SER_LO |-> rdata == SERIAL_NUMBER[15:0])
    else $error("serial low word wrong");
  AST_SER_HI: assert property (
    rd_ack && addr == srs_pkg::OFS_SER_HI |-> rdata == SERIAL_NUMBER[31:16])
    else $error("serial high word wrong");
  AST_RSV_ZERO: assert property (
    rd_ack && (addr == srs_pkg::OFS_MAIN || addr == srs_pkg::OFS_SYNC)
    |-> (rdata & RSV_MASK) == 16'h0000) else $error("reserved status bit set");
endmodule

// file: verification/srs_tb.sv
// bench: apb master drives the host controller, which talks to the device
// assumes package, link interface, both ends and the checker are compiled
`timescale 1ns/100ps
module srs_tb;
  localparam logic [31:0] SER = 32'h1234_abcd; // arbitrary value
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, xv, r;
  logic temp_load, press_load, result_clamped, chip_idle, results_blocked;
  logic bridge_supply_fault, bridge_check_fault, link_crc_fault, cfg_crc_fault;
  logic [15:0] temp_value, press_value;
  // model state: results, events, clamp, block, synced bits 4:3
  logic [15:0] t_m, p_m, ev_m;
  logic sat_m, blk_m;
  logic [1:0] s34_m;
  logic [1:0] seen_m; // update flags seen by status reads, [1] temp
  logic [31:0] seed = 32'h86e9;
  int err_count = 0;
  int compares = 0;

  srs_link_if srs_link_if_i();
  srs_device #(.SERIAL_NUMBER(SER)) srs_device_i (.clk, .rst_b, .link(srs_link_if_i),
    .temp_load, .temp_value, .press_load, .press_value, .result_clamped, .chip_idle,
    .bridge_supply_fault, .bridge_check_fault, .link_crc_fault, .cfg_crc_fault,
    .results_blocked);
  srs_host srs_host_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link(srs_link_if_i));
  srs_link_sva #(.SERIAL_NUMBER(SER)) srs_link_sva_i (.clk, .rst_b,
    .req(srs_link_if_i.req), .we(srs_link_if_i.we), .addr(srs_link_if_i.addr),
    .wdata(srs_link_if_i.wdata), .ack(srs_link_if_i.ack), .rdata(srs_link_if_i.rdata));

  // free-running clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] main_exp();
    return ev_m | {5'h00, sat_m, 9'h000, chip_idle};
  endfunction
  function automatic logic [15:0] rd_exp(input logic [7:0] a);
    case (a)
      srs_pkg::OFS_TEMP: return t_m;
      srs_pkg::OFS_PRESS: return p_m;
      srs_pkg::OFS_SYNC: return (main_exp() & srs_pkg::SYNC_COPY_MASK) | {11'h0, s34_m, 3'h0};
      srs_pkg::OFS_MAIN: return main_exp();
      srs_pkg::OFS_SER_LO: return SER[15:0];
      srs_pkg::OFS_SER_HI: return SER[31:16];
      default: return 16'h0000; // unmapped reads give zero
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      test_done();
    end
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link order through the controller; leaves first word in rv
  task automatic link(input logic w, input logic [7:0] a, input logic [15:0] d, input logic b);
    int n;
    if (w) apb(1'b1, srs_pkg::H_WDATA, {16'h0000, d});
    apb(1'b1, srs_pkg::H_CTRL, {22'h0, b, w, a});
    for (n = 0; n < 40; n++) begin
      apb(1'b0, srs_pkg::H_STAT, 32'h0);
      if (rv[srs_pkg::STAT_BUSY] === 1'b0) break;
    end
    if (n == 40) begin
      err_count++;
      test_done();
    end
    apb(1'b0, srs_pkg::H_RD0, 32'h0);
  endtask
  // read side effects: flag copied to synced word, then cleared
  task automatic rd_fx(input logic [7:0] a);
    if (a == srs_pkg::OFS_TEMP) begin
      s34_m[1] = ev_m[4];
      ev_m[4] = 1'b0;
    end
    if (a == srs_pkg::OFS_PRESS) begin
      s34_m[0] = ev_m[3];
      ev_m[3] = 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    link(1'b0, a, 16'h0000, 1'b0);
    xv = {16'h0000, rd_exp(a)};
    // only status words count towards the host's ready flag
    if (a == srs_pkg::OFS_MAIN || a == srs_pkg::OFS_SYNC) seen_m |= xv[4:3];
    rd_fx(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    link(1'b1, a, d, 1'b0);
    if (a == srs_pkg::OFS_MAIN) ev_m &= ~d;
  endtask
  task automatic burst();
    link(1'b0, 8'h00, 16'h0000, 1'b1);
    check(rv, {16'h0000, t_m});
    rd_fx(srs_pkg::OFS_TEMP);
    rd_fx(srs_pkg::OFS_PRESS);
    apb(1'b0, srs_pkg::H_RD1, 32'h0);
    check(rv, {16'h0000, p_m});
    apb(1'b0, srs_pkg::H_RD2, 32'h0);
    check(rv, {16'h0000, rd_exp(srs_pkg::OFS_SYNC)});
    seen_m |= s34_m;
    apb(1'b0, srs_pkg::H_STAT, 32'h0);
    check({29'h0, rv[3:1]}, {29'h0, s34_m[0], s34_m[1], &seen_m});
  endtask
  // one result load; a load over a set up flag marks it missed
  task automatic load(input logic t, input logic [15:0] v, input logic c);
    @(posedge clk);
    temp_load <= t;
    press_load <= !t;
    temp_value <= v;
    press_value <= v;
    result_clamped <= c;
    @(posedge clk);
    temp_load <= 1'b0;
    press_load <= 1'b0;
    if (!blk_m && t) begin
      ev_m[15] |= ev_m[4];
      ev_m[4] = 1'b1;
      t_m = v;
    end
    if (!blk_m && !t) begin
      ev_m[14] |= ev_m[3];
      ev_m[3] = 1'b1;
      p_m = v;
    end
    if (!blk_m) sat_m = c;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {temp_load, press_load, result_clamped, chip_idle, cfg_crc_fault} = '0;
    {bridge_supply_fault, bridge_check_fault, link_crc_fault} = '0;
    {temp_value, press_value, ev_m, sat_m, blk_m, s34_m, seen_m} = '0;
    t_m = srs_pkg::WORD_RESET;
    p_m = srs_pkg::WORD_RESET;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    chip_idle <= 1'b1;
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    // no update seen yet, so results are not to be trusted
    apb(1'b0, srs_pkg::H_STAT, 32'h0);
    check({31'h0, rv[srs_pkg::STAT_READY]}, {31'h0, &seen_m});
    r = rnd();
    load(1'b1, r[15:0], 1'b0);
    load(1'b0, r[31:16], 1'b1);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    apb(1'b0, srs_pkg::H_STAT, 32'h0);
    check({31'h0, rv[srs_pkg::STAT_READY]}, {31'h0, &seen_m});
    load(1'b1, ~r[15:0], 1'b0);
    load(1'b0, ~r[31:16], 1'b0);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    rd(srs_pkg::OFS_TEMP);
    check(rv, xv);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    rd(srs_pkg::OFS_PRESS);
    check(rv, xv);
    rd(srs_pkg::OFS_SYNC);
    check(rv, xv);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    // fault events, then clear writes to both status words; only main status clears
    @(posedge clk);
    {link_crc_fault, bridge_check_fault, bridge_supply_fault} <= 3'h7;
    @(posedge clk);
    {link_crc_fault, bridge_check_fault, bridge_supply_fault} <= 3'h0;
    ev_m = ev_m | 16'h0980;
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    rd(srs_pkg::OFS_SYNC);
    check(rv, xv);
    wr(srs_pkg::OFS_SYNC, 16'hffff);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    wr(srs_pkg::OFS_MAIN, 16'h0080);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    wr(srs_pkg::OFS_MAIN, 16'hffff);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    // write protection, serial number, unmapped controller address
    wr(srs_pkg::OFS_SER_LO, 16'h0f0f);
    wr(srs_pkg::OFS_PRESS, 16'h0f0f);
    rd(srs_pkg::OFS_SER_LO);
    check(rv, xv);
    rd(srs_pkg::OFS_SER_HI);
    check(rv, xv);
    rd(srs_pkg::OFS_PRESS);
    check(rv, xv);
    apb(1'b0, 12'h018, 32'h0);
    check({rv[30:0], se}, 32'h1);
    // random loads between three-word reads
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      chip_idle <= r[0];
      if (r[1]) load(1'b1, r[31:16], r[2]);
      if (r[3]) load(1'b0, r[23:8], r[4]);
      burst();
    end
    // configuration fault stops every later load
    @(posedge clk);
    cfg_crc_fault <= 1'b1;
    @(posedge clk);
    cfg_crc_fault <= 1'b0;
    blk_m = 1'b1;
    #1;
    check({31'h0, results_blocked}, 32'h1);
    load(1'b1, ~t_m, 1'b1);
    rd(srs_pkg::OFS_TEMP);
    check(rv, xv);
    rd(srs_pkg::OFS_MAIN);
    check(rv, xv);
    test_done();
  end
endmodule
